//--- inc/wdt_pkg.sv
package wdt_pkg;

   // Register port widths.
   localparam int unsigned ADDR_W = 4;
   localparam int unsigned DATA_W = 8;

   // Register offsets.
   localparam logic [ADDR_W-1:0] OFF_CONTROL = 4'h0;
   localparam logic [ADDR_W-1:0] OFF_STATUS = 4'h1;
   localparam logic [ADDR_W-1:0] OFF_COUNT_LO = 4'h2;
   localparam logic [ADDR_W-1:0] OFF_COUNT_HI = 4'h3;

   // Control register field positions.
   localparam int unsigned CTL_ENABLE_BIT = 7;
   localparam int unsigned CTL_CLEAR_BIT = 6;
   localparam int unsigned CTL_IDLE_RUN_BIT = 5;
   localparam int unsigned CTL_PSEL_LSB = 0;
   localparam int unsigned PSEL_W = 3;

   // Status register field positions.
   localparam int unsigned STS_FLAG_BIT = 0;
   localparam int unsigned STS_RST_EN_BIT = 1;

   // Reset values.
   localparam logic [DATA_W-1:0] CONTROL_RESET = 8'h00;
   localparam logic [DATA_W-1:0] STATUS_RESET = 8'h00;

   // Timing counts, in system clock cycles or machine cycles, and counter widths in bits.
   localparam int unsigned MACHINE_CLKS = 12;
   localparam int unsigned RESET_MCYCLES = 2;
   localparam int unsigned COUNT_WIDTH = 14;
   localparam int unsigned PRESCALE_WIDTH = 8;

   // One register-port request.
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } reg_req_t;

   // Terminal count mask of the prescaler for each select code.
   function automatic logic [PRESCALE_WIDTH-1:0] psel_mask(
      input logic [PSEL_W-1:0] sel);
      logic [PRESCALE_WIDTH-1:0] m;
      m = 8'h01;
      case (sel)
         3'h0: m = 8'h01;
         3'h2: m = 8'h03;
         3'h1: m = 8'h07;
         3'h3: m = 8'h0f;
         3'h4: m = 8'h1f;
         3'h5: m = 8'h3f;
         3'h6: m = 8'h7f;
         3'h7: m = 8'hff;
         default: m = 8'h01;
      endcase
      return m;
   endfunction : psel_mask

endpackage : wdt_pkg

//--- logic/watchdog_timer_prescaled.sv
`timescale 1ns/1ns
// Overview of operation
// - The watchdog is a divider chain advanced once per machine cycle of the system clock whose selected tap sets the time-out interval.
// - At time-out a flag is set, and a system reset is raised only if the reset action is enabled.
// - After chip reset the watchdog is disabled and does not count until software enables it.
// - The chain counts while watchdog_enable is one (in idle only with watchdog_run_in_idle set) and stops while it is zero.
// - Writing one to watchdog_clear clears the 14-bit counter and the prescaler.
// - The counter, prescaler and watchdog_clear itself are cleared on the next instruction cycle after the write.
// - In idle the watchdog runs only when watchdog_run_in_idle is one, and that bit resets to zero.
// - The 3-bit prescale select gives ratios 000=2, 010=4, 001=8, 011=16, 100=32, 101=64, 110=128, 111=256.
// - The time-out period is 2 to the 14th times the prescaler ratio times 12 oscillator periods.
// - Chip reset clears the counter and prescaler to zero.
module watchdog_timer_prescaled #(
   parameter int unsigned MACHINE_CLKS = wdt_pkg::MACHINE_CLKS,
   parameter int unsigned COUNT_WIDTH = wdt_pkg::COUNT_WIDTH,
   parameter int unsigned RESET_MCYCLES = wdt_pkg::RESET_MCYCLES
) (
   input wire logic clk_sys_i,
   input wire logic reset_n_i,
   input wire wdt_pkg::reg_req_t reg_req_i,
   input wire logic idle_mode_i,
   output logic [wdt_pkg::DATA_W-1:0] rd_data_o,
   output logic timeout_flag_o,
   output logic sys_reset_o
);

   localparam int unsigned RESET_CLKS = RESET_MCYCLES * MACHINE_CLKS;
   localparam int unsigned MC_W = $clog2(MACHINE_CLKS + 1);
   localparam int unsigned RC_W = $clog2(RESET_CLKS + 1);
   localparam logic [MC_W-1:0] MC_LAST = MC_W'(MACHINE_CLKS - 1);
   localparam logic [RC_W-1:0] RC_LOAD = RC_W'(RESET_CLKS);
   localparam int unsigned PW = wdt_pkg::PRESCALE_WIDTH;

   generate
      if (MACHINE_CLKS < 2 || COUNT_WIDTH < 9 || COUNT_WIDTH > 16 ||
          RESET_MCYCLES < 2) begin : g_bad_params
         $error("watchdog_timer_prescaled: unsupported parameter values");
      end
   endgenerate

   logic [MC_W-1:0] mc_cnt_q;
   logic mc_tick;
   logic enable_q;
   logic clear_q;
   logic idle_run_q;
   logic [wdt_pkg::PSEL_W-1:0] psel_q;
   logic reset_enable_q;
   logic flag_q;
   logic [PW-1:0] pre_q;
   logic [COUNT_WIDTH-1:0] cnt_q;
   logic [RC_W-1:0] rst_cnt_q;
   logic sys_reset_q;
   logic [wdt_pkg::DATA_W-1:0] rd_data_q;
   logic running;
   logic pre_wrap;
   logic timeout;
   logic wd_fire;
   logic wr_ctl;
   logic wr_sts;
   logic [wdt_pkg::DATA_W-1:0] ctl_view;
   logic [wdt_pkg::DATA_W-1:0] sts_view;
   logic [15:0] cnt_wide;

   assign wr_ctl = reg_req_i.wr && (reg_req_i.addr == wdt_pkg::OFF_CONTROL);
   assign wr_sts = reg_req_i.wr && (reg_req_i.addr == wdt_pkg::OFF_STATUS);

   assign mc_tick = (mc_cnt_q == MC_LAST);

   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         mc_cnt_q <= '0;
      end else if (mc_tick) begin
         mc_cnt_q <= '0;
      end else begin
         mc_cnt_q <= mc_cnt_q + MC_W'(1);
      end
   end

   assign running = enable_q && (!idle_mode_i || idle_run_q);

   assign pre_wrap = (pre_q == wdt_pkg::psel_mask(psel_q));

   assign timeout = mc_tick && running && !clear_q && pre_wrap &&
                    (&cnt_q);
   assign wd_fire = timeout && reset_enable_q;

   // Control register; a watchdog reset returns it to its reset state.
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         enable_q <= wdt_pkg::CONTROL_RESET[wdt_pkg::CTL_ENABLE_BIT];
         idle_run_q <= wdt_pkg::CONTROL_RESET[wdt_pkg::CTL_IDLE_RUN_BIT];
         psel_q <= wdt_pkg::CONTROL_RESET[wdt_pkg::CTL_PSEL_LSB +:
                                          wdt_pkg::PSEL_W];
      end else if (wd_fire) begin
         enable_q <= wdt_pkg::CONTROL_RESET[wdt_pkg::CTL_ENABLE_BIT];
         idle_run_q <= wdt_pkg::CONTROL_RESET[wdt_pkg::CTL_IDLE_RUN_BIT];
         psel_q <= wdt_pkg::CONTROL_RESET[wdt_pkg::CTL_PSEL_LSB +:
                                          wdt_pkg::PSEL_W];
      end else if (wr_ctl) begin
         enable_q <= reg_req_i.wdata[wdt_pkg::CTL_ENABLE_BIT];
         idle_run_q <= reg_req_i.wdata[wdt_pkg::CTL_IDLE_RUN_BIT];
         psel_q <= reg_req_i.wdata[wdt_pkg::CTL_PSEL_LSB +:
                                   wdt_pkg::PSEL_W];
      end
   end

   // Self-clearing clear request; a new write wins over the clearing tick.
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         clear_q <= wdt_pkg::CONTROL_RESET[wdt_pkg::CTL_CLEAR_BIT];
      end else if (wr_ctl && reg_req_i.wdata[wdt_pkg::CTL_CLEAR_BIT]) begin
         clear_q <= 1'b1;
      end else if (mc_tick || wd_fire) begin
         clear_q <= 1'b0;
      end
   end

   // Reset action enable and time-out flag.
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         reset_enable_q <= wdt_pkg::STATUS_RESET[wdt_pkg::STS_RST_EN_BIT];
      end else if (wr_sts) begin
         reset_enable_q <= reg_req_i.wdata[wdt_pkg::STS_RST_EN_BIT];
      end
   end

   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         flag_q <= wdt_pkg::STATUS_RESET[wdt_pkg::STS_FLAG_BIT];
      end else if (timeout) begin
         flag_q <= 1'b1;
      end else if (wr_sts && !reg_req_i.wdata[wdt_pkg::STS_FLAG_BIT]) begin
         flag_q <= 1'b0;
      end
   end

   // Prescaler and time-out counter.
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         pre_q <= '0;
         cnt_q <= '0;
      end else if (wd_fire) begin
         pre_q <= '0;
         cnt_q <= '0;
      end else if (mc_tick && clear_q) begin
         pre_q <= '0;
         cnt_q <= '0;
      end else if (mc_tick && running) begin
         if (pre_wrap) begin
            pre_q <= '0;
            cnt_q <= cnt_q + COUNT_WIDTH'(1);
         end else begin
            pre_q <= pre_q + PW'(1);
         end
      end
   end

   // System reset pulse.
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rst_cnt_q <= '0;
         sys_reset_q <= 1'b0;
      end else if (wd_fire) begin
         rst_cnt_q <= RC_LOAD;
         sys_reset_q <= 1'b1;
      end else if (rst_cnt_q > RC_W'(1)) begin
         rst_cnt_q <= rst_cnt_q - RC_W'(1);
      end else begin
         rst_cnt_q <= '0;
         sys_reset_q <= 1'b0;
      end
   end

   // Read views.
   always_comb begin
      ctl_view = '0;
      ctl_view[wdt_pkg::CTL_ENABLE_BIT] = enable_q;
      ctl_view[wdt_pkg::CTL_CLEAR_BIT] = clear_q;
      ctl_view[wdt_pkg::CTL_IDLE_RUN_BIT] = idle_run_q;
      ctl_view[wdt_pkg::CTL_PSEL_LSB +: wdt_pkg::PSEL_W] = psel_q;
      sts_view = '0;
      sts_view[wdt_pkg::STS_FLAG_BIT] = flag_q;
      sts_view[wdt_pkg::STS_RST_EN_BIT] = reset_enable_q;
      cnt_wide = 16'(cnt_q);
   end

   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rd_data_q <= '0;
      end else if (reg_req_i.rd) begin
         case (reg_req_i.addr)
            wdt_pkg::OFF_CONTROL: rd_data_q <= ctl_view;
            wdt_pkg::OFF_STATUS: rd_data_q <= sts_view;
            wdt_pkg::OFF_COUNT_LO: rd_data_q <= cnt_wide[7:0];
            wdt_pkg::OFF_COUNT_HI: rd_data_q <= cnt_wide[15:8];
            default: rd_data_q <= '0;
         endcase
      end else begin
         rd_data_q <= '0;
      end
   end

   assign rd_data_o = rd_data_q;
   assign timeout_flag_o = flag_q;
   assign sys_reset_o = sys_reset_q;

endmodule : watchdog_timer_prescaled

//--- bench/wdt_properties.sv
`timescale 1ns/1ns
module wdt_properties #(
   parameter int unsigned MACHINE_CLKS = 12,
   parameter int unsigned RESET_MCYCLES = 2
) (
   input wire logic clk_sys_i,
   input wire logic reset_n_i,
   input wire wdt_pkg::reg_req_t reg_req_i,
   input wire logic idle_mode_i,
   input wire logic [wdt_pkg::DATA_W-1:0] rd_data_o,
   input wire logic timeout_flag_o,
   input wire logic sys_reset_o
);
   logic [7:0] len_q;
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         len_q <= 8'h00;
      end else begin
         len_q <= sys_reset_o ? len_q + 8'h01 : 8'h00;
      end
   end
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!reset_n_i);
   a_reset_len: assert property (
      $fell(sys_reset_o) |-> len_q == MACHINE_CLKS * RESET_MCYCLES)
      else $error("reset pulse length wrong");
   a_reset_max: assert property (
      sys_reset_o |-> len_q < MACHINE_CLKS * RESET_MCYCLES)
      else $error("reset pulse too long");
   a_reset_hold: assert property (
      $rose(sys_reset_o) |=> sys_reset_o [*8])
      else $error("reset pulse too short");
   a_flag_with_reset: assert property (
      $rose(sys_reset_o) |-> timeout_flag_o)
      else $error("reset without flag");
   a_read_quiet: assert property (
      !$past(reg_req_i.rd) |-> rd_data_o == 8'h00)
      else $error("read data outside read slot");
   a_flag_hold: assert property (
      $fell(timeout_flag_o) |-> $past(reg_req_i.wr && !reg_req_i.wdata[0]
      && reg_req_i.addr == wdt_pkg::OFF_STATUS))
      else $error("flag cleared without write");
   a_flag_kept: assert property (
      sys_reset_o && !(reg_req_i.wr && reg_req_i.addr == wdt_pkg::OFF_STATUS)
      |=> timeout_flag_o) else $error("flag lost in reset");
   a_ctl_spare: assert property (
      $past(reg_req_i.rd && reg_req_i.addr == wdt_pkg::OFF_CONTROL)
      |-> rd_data_o[4:3] == 2'h0) else $error("spare control bits set");
endmodule : wdt_properties

//--- bench/tb.sv
`timescale 1ns/1ns
module tb;
   logic clk_sys_i = 1'b0;
   logic reset_n_i = 1'b0;
   logic idle_mode_i = 1'b0;
   wdt_pkg::reg_req_t req = '0;
   logic [wdt_pkg::DATA_W-1:0] rd_data_o;
   logic timeout_flag_o;
   logic sys_reset_o;
   logic [7:0] v;
   int fails = 0;
   int check_count = 0;
   int cyc = 0;
   int n;
   int unsigned ratio [8] = '{2, 8, 4, 16, 32, 64, 128, 256};
   always #4 clk_sys_i = ~clk_sys_i;
   watchdog_timer_prescaled #(.COUNT_WIDTH(9)) dut (
      .clk_sys_i(clk_sys_i),
      .reset_n_i(reset_n_i),
      .reg_req_i(req),
      .idle_mode_i(idle_mode_i),
      .rd_data_o(rd_data_o),
      .timeout_flag_o(timeout_flag_o),
      .sys_reset_o(sys_reset_o)
   );
   task automatic summarize();
      $display("checks %0d fails %0d", check_count, fails);
      if (fails == 0 && check_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : summarize
   always @(posedge clk_sys_i) begin
      cyc <= cyc + 1;
      if (cyc == 80000) begin
         fails++;
         summarize();
      end
   end
   task automatic chk(string s, logic [7:0] e, logic [7:0] g);
      check_count++;
      if (g !== e) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", s, e, g);
      end
   endtask : chk
   task automatic wr(logic [3:0] ad, logic [7:0] d);
      @(posedge clk_sys_i);
      req <= '{ad, d, 1'b1, 1'b0};
      @(posedge clk_sys_i);
      req <= '0;
   endtask : wr
   task automatic rchk(string s, logic [3:0] ad, logic [7:0] e);
      @(posedge clk_sys_i);
      req <= '{ad, 8'h00, 1'b0, 1'b1};
      @(posedge clk_sys_i);
      req <= '0;
      #1 v = rd_data_o;
      chk(s, e, v);
   endtask : rchk
   task automatic wait_flag();
      n = 0;
      while (timeout_flag_o !== 1'b1 && n < 30000) begin
         @(posedge clk_sys_i);
         #1 n++;
      end
   endtask : wait_flag
   initial begin
      repeat (12) @(posedge clk_sys_i);
      reset_n_i <= 1'b1;
      repeat (2000) @(posedge clk_sys_i);
      rchk("control", wdt_pkg::OFF_CONTROL, 8'h00);
      rchk("count", wdt_pkg::OFF_COUNT_LO, 8'h00);
      rchk("unmapped", 4'h9, 8'h00);
      wr(wdt_pkg::OFF_CONTROL, 8'h9a);
      rchk("control", wdt_pkg::OFF_CONTROL, 8'h82);
      for (int s = 0; s < 8; s++) begin
         wr(wdt_pkg::OFF_CONTROL, 8'hc0 | 8'(s));
         repeat (13 + 36 * ratio[s]) @(posedge clk_sys_i);
         rchk("ratio", wdt_pkg::OFF_COUNT_LO, 8'h03);
      end
      wr(wdt_pkg::OFF_CONTROL, 8'hc7);
      repeat (13) @(posedge clk_sys_i);
      rchk("control", wdt_pkg::OFF_CONTROL, 8'h87);
      rchk("count", wdt_pkg::OFF_COUNT_LO, 8'h00);
      @(posedge clk_sys_i) idle_mode_i <= 1'b1;
      repeat (3100) @(posedge clk_sys_i);
      rchk("idle halt", wdt_pkg::OFF_COUNT_LO, 8'h00);
      wr(wdt_pkg::OFF_CONTROL, 8'ha7);
      repeat (3100) @(posedge clk_sys_i);
      rchk("control", wdt_pkg::OFF_CONTROL, 8'ha7);
      rchk("idle run", wdt_pkg::OFF_COUNT_LO, 8'h01);
      @(posedge clk_sys_i) idle_mode_i <= 1'b0;
      wr(wdt_pkg::OFF_CONTROL, 8'hc0);
      repeat (8000) @(posedge clk_sys_i);
      rchk("count hi", wdt_pkg::OFF_COUNT_HI, 8'h01);
      wr(wdt_pkg::OFF_CONTROL, 8'hc0);
      wait_flag();
      chk("period", 8'h01, {7'h0, n > 12288 && n < 12303});
      chk("no reset", 8'h00, {7'h0, sys_reset_o});
      wr(wdt_pkg::OFF_STATUS, 8'h03);
      rchk("status", wdt_pkg::OFF_STATUS, 8'h03);
      wr(wdt_pkg::OFF_STATUS, 8'h02);
      rchk("status", wdt_pkg::OFF_STATUS, 8'h02);
      wr(wdt_pkg::OFF_CONTROL, 8'hc0);
      wait_flag();
      chk("reset", 8'h01, {7'h0, sys_reset_o});
      repeat (30) @(posedge clk_sys_i);
      rchk("control", wdt_pkg::OFF_CONTROL, 8'h00);
      rchk("status", wdt_pkg::OFF_STATUS, 8'h03);
      summarize();
   end
endmodule : tb
bind watchdog_timer_prescaled wdt_properties #(
   .MACHINE_CLKS(MACHINE_CLKS),
   .RESET_MCYCLES(RESET_MCYCLES)
) u_chk (
   .clk_sys_i(clk_sys_i),
   .reset_n_i(reset_n_i),
   .reg_req_i(reg_req_i),
   .idle_mode_i(idle_mode_i),
   .rd_data_o(rd_data_o),
   .timeout_flag_o(timeout_flag_o),
   .sys_reset_o(sys_reset_o)
);
